// [verilog/sgio_defs.svh]
`ifndef SGIO_DEFS_SVH
`define SGIO_DEFS_SVH
// Overview of operation
// RL1 - Eleven pins are each set on their own as input, output or alternate function.
// RL2 - Pins 0, 1, 9 and 10 output the port 2, 4, 3 and 5 resets, and pin 7 the event output.
// RL3 - Pins 2, 3 and 4 are input alternates that carry the interrupts of expanders 0, 1 and 2.
// RL4 - Function, direction and data registers sit in the upstream port's configuration space.
// RL5 - Each pin owns one bit position in each of the three registers.
// RL6 - Function 1 is alternate; otherwise direction 1 is output and direction 0 is input.
// RL7 - After reset every pin is a general purpose input.
// RL8 - Pin inputs are synchronised and sampled no more often than once per 128 ns.
// RL9 - A pin in general purpose mode holds its unused alternate function inactive.
// RL10 - In input mode the sampled pin level is captured into the pin's data bit.
// RL11 - Reading the data register returns the real pin level in every mode.
// RL12 - In output mode the pin is driven with the pin's data value.
// RL13 - Data writes load a latch that output pins drive, while reads return the pin level.

`define SGIO_NUM_PINS 11
`define SGIO_CFG_WIDTH 32

// Register selects of the configuration access port
`define SGIO_SEL_FUNC 2'h0
`define SGIO_SEL_DIR 2'h1
`define SGIO_SEL_DATA 2'h2

// Alternate function layout: bits 0,1,7,9,10 drive out, bits 2,3,4 come in
`define SGIO_ALT_OUT_MASK 11'h683
`define SGIO_ALT_IN_MASK 11'h01c
`define SGIO_PIN_PORT2_RST 0
`define SGIO_PIN_PORT4_RST 1
`define SGIO_PIN_EXP0_IRQ 2
`define SGIO_PIN_EXP1_IRQ 3
`define SGIO_PIN_EXP2_IRQ 4
`define SGIO_PIN_EVENT 7
`define SGIO_PIN_PORT3_RST 9
`define SGIO_PIN_PORT5_RST 10

// Reset values
`define SGIO_FUNC_RST 11'h000
`define SGIO_DIR_RST 11'h000
`define SGIO_LATCH_RST 11'h000
`define SGIO_DATA_RST 11'h000
`define SGIO_SYNC_RST 1'b1
`define SGIO_IRQ_INACTIVE 1'b1

// Timing
`define SGIO_CLK_PERIOD_NS 50
`define SGIO_SAMPLE_MIN_NS 128
`define SGIO_SAMPLE_CYC ((`SGIO_SAMPLE_MIN_NS + `SGIO_CLK_PERIOD_NS - 1) / `SGIO_CLK_PERIOD_NS)
`endif

// [verilog/sgio_pkg.sv]
`include "sgio_defs.svh"
package sgio_pkg;
   typedef enum logic [2:0]
   {
      SGIO_MODE_IN = 3'h1,
      SGIO_MODE_OUT = 3'h2,
      SGIO_MODE_ALT = 3'h4
   } sgio_mode_t;

   typedef enum logic [1:0]
   {
      SGIO_REG_FUNC = `SGIO_SEL_FUNC,
      SGIO_REG_DIR = `SGIO_SEL_DIR,
      SGIO_REG_DATA = `SGIO_SEL_DATA
   } sgio_reg_sel_t;
endpackage

// [verilog/sgio_pin_cell.sv]
`include "sgio_defs.svh"
module sgio_pin_cell
   import sgio_pkg::*;
#(
   parameter bit ALT_OUT = 1'b0,
   parameter bit ALT_IN = 1'b0
)
(
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic func_i,
   input wire logic dir_i,
   input wire logic latch_i,
   input wire logic alt_out_i,
   input wire logic pad_in_i,
   output logic pad_out_o,
   output logic pad_oe_o,
   output logic level_o,
   output logic alt_in_o
);
   sgio_mode_t mode;
   logic sync1_r, sync1_nxt;
   logic sync2_r, sync2_nxt;
   logic out_r, out_nxt;
   logic oe_r, oe_nxt;
   logic alt_in_r, alt_in_nxt;

   always_comb
   begin
      // Function bit wins over direction
      if (func_i)
      begin
         mode = SGIO_MODE_ALT; // [RL6]
      end
      else if (dir_i)
      begin
         mode = SGIO_MODE_OUT; // [RL6]
      end
      else
      begin
         mode = SGIO_MODE_IN; // [RL6]
      end
      sync1_nxt = pad_in_i; // [RL8]
      sync2_nxt = sync1_r; // [RL8]
      out_nxt = 1'b0;
      oe_nxt = 1'b0;
      alt_in_nxt = `SGIO_IRQ_INACTIVE; // [RL9]
      case (mode)
         SGIO_MODE_IN:
         begin
            oe_nxt = 1'b0;
         end
         SGIO_MODE_OUT:
         begin
            out_nxt = latch_i; // [RL12] [RL13]
            oe_nxt = 1'b1; // [RL12]
         end
         SGIO_MODE_ALT:
         begin
            // Pins with no alternate simply float when set to alternate
            if (ALT_OUT)
            begin
               out_nxt = alt_out_i; // [RL2]
               oe_nxt = 1'b1; // [RL2]
            end
            if (ALT_IN)
            begin
               alt_in_nxt = sync2_r; // [RL3]
            end
         end
         default:
         begin
            oe_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         sync1_r <= `SGIO_SYNC_RST;
         sync2_r <= `SGIO_SYNC_RST;
         out_r <= 1'b0;
         oe_r <= 1'b0; // [RL7]
         alt_in_r <= `SGIO_IRQ_INACTIVE;
      end
      else
      begin
         sync1_r <= sync1_nxt;
         sync2_r <= sync2_nxt;
         out_r <= out_nxt;
         oe_r <= oe_nxt;
         alt_in_r <= alt_in_nxt;
      end
   end

   assign pad_out_o = out_r;
   assign pad_oe_o = oe_r;
   assign level_o = sync2_r;
   assign alt_in_o = alt_in_r;
endmodule // sgio_pin_cell

// [verilog/sgio_gpio.sv]
`include "sgio_defs.svh"
module sgio_gpio
   import sgio_pkg::*;
#(
   parameter int NUM_PINS = `SGIO_NUM_PINS,
   parameter int SAMPLE_CYC = `SGIO_SAMPLE_CYC
)
(
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // Configuration space access
   input wire logic cfg_wr_i,
   input wire logic cfg_rd_i,
   input wire logic [1:0] cfg_sel_i,
   input wire logic [`SGIO_CFG_WIDTH-1:0] cfg_wdata_i,
   input wire logic [3:0] cfg_be_i,
   output logic [`SGIO_CFG_WIDTH-1:0] cfg_rdata_o,
   output logic cfg_rvalid_o,
   // Register contents for the rest of the port
   output logic [NUM_PINS-1:0] pin_function_select_o,
   output logic [NUM_PINS-1:0] pin_direction_config_o,
   output logic [NUM_PINS-1:0] pin_data_value_o,
   // Pads
   input wire logic [NUM_PINS-1:0] gpio_in_i,
   output logic [NUM_PINS-1:0] gpio_out_o,
   output logic [NUM_PINS-1:0] gpio_oe_o,
   // Alternate function sources from the core, active low
   input wire logic port2_reset_out_n_i,
   input wire logic port3_reset_out_n_i,
   input wire logic port4_reset_out_n_i,
   input wire logic port5_reset_out_n_i,
   input wire logic general_event_out_n_i,
   // Alternate function sinks to the core, active low
   output logic expander0_irq_in_n_o,
   output logic expander1_irq_in_n_o,
   output logic expander2_irq_in_n_o
);
   localparam int CNT_W = (SAMPLE_CYC > 1) ? $clog2(SAMPLE_CYC) : 1;
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SAMPLE_CYC - 1);
   localparam logic [NUM_PINS-1:0] ALT_OUT_MASK = NUM_PINS'(`SGIO_ALT_OUT_MASK);
   localparam logic [NUM_PINS-1:0] ALT_IN_MASK = NUM_PINS'(`SGIO_ALT_IN_MASK);

   logic [NUM_PINS-1:0] func_r, func_nxt;
   logic [NUM_PINS-1:0] dir_r, dir_nxt;
   logic [NUM_PINS-1:0] latch_r, latch_nxt;
   logic [NUM_PINS-1:0] data_r, data_nxt;
   logic [`SGIO_CFG_WIDTH-1:0] rdata_r, rdata_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic sample_tick;
   logic [NUM_PINS-1:0] alt_out_vec;
   logic [NUM_PINS-1:0] level_vec;
   logic [NUM_PINS-1:0] alt_in_vec;
   sgio_reg_sel_t sel;

   // Each byte enable covers eight bits so a partial write leaves other lanes intact
   function automatic logic [NUM_PINS-1:0] merge_bits(
      input logic [NUM_PINS-1:0] old_v,
      input logic [`SGIO_CFG_WIDTH-1:0] new_v,
      input logic [3:0] be
   );
      logic [NUM_PINS-1:0] res;
      res = old_v;
      for (int i = 0; i < NUM_PINS; i++)
      begin
         if (be[i / 8])
         begin
            res[i] = new_v[i]; // [RL5]
         end
      end
      return res;
   endfunction

   always_comb
   begin
      alt_out_vec = '1;
      alt_out_vec[`SGIO_PIN_PORT2_RST] = port2_reset_out_n_i; // [RL2]
      alt_out_vec[`SGIO_PIN_PORT4_RST] = port4_reset_out_n_i; // [RL2]
      alt_out_vec[`SGIO_PIN_EVENT] = general_event_out_n_i; // [RL2]
      alt_out_vec[`SGIO_PIN_PORT3_RST] = port3_reset_out_n_i; // [RL2]
      alt_out_vec[`SGIO_PIN_PORT5_RST] = port5_reset_out_n_i; // [RL2]
   end

   // One cell per pin keeps each pin independent of the others
   for (genvar p = 0; p < NUM_PINS; p++)
   begin : g_pin
      sgio_pin_cell #(
         .ALT_OUT(ALT_OUT_MASK[p]),
         .ALT_IN(ALT_IN_MASK[p])
      ) u_cell (
         .mclk_i(mclk_i),
         .rst_b_i(rst_b_i),
         .func_i(func_r[p]),
         .dir_i(dir_r[p]),
         .latch_i(latch_r[p]),
         .alt_out_i(alt_out_vec[p]),
         .pad_in_i(gpio_in_i[p]),
         .pad_out_o(gpio_out_o[p]),
         .pad_oe_o(gpio_oe_o[p]),
         .level_o(level_vec[p]),
         .alt_in_o(alt_in_vec[p])
      ); // [RL1]
   end

   assign expander0_irq_in_n_o = alt_in_vec[`SGIO_PIN_EXP0_IRQ]; // [RL3]
   assign expander1_irq_in_n_o = alt_in_vec[`SGIO_PIN_EXP1_IRQ]; // [RL3]
   assign expander2_irq_in_n_o = alt_in_vec[`SGIO_PIN_EXP2_IRQ]; // [RL3]

   // Sample interval timer
   always_comb
   begin
      sample_tick = (cnt_r == CNT_LAST);
      if (sample_tick)
      begin
         cnt_nxt = '0; // [RL8]
      end
      else
      begin
         cnt_nxt = cnt_r + CNT_W'(1); // [RL8]
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         cnt_r <= '0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
      end
   end

   // Register file
   always_comb
   begin
      sel = sgio_reg_sel_t'(cfg_sel_i);
      func_nxt = func_r;
      dir_nxt = dir_r;
      latch_nxt = latch_r;
      data_nxt = data_r;
      // Data bit follows the pin level in every mode, not only input mode
      if (sample_tick)
      begin
         data_nxt = level_vec; // [RL10] [RL11] [RL8]
      end
      if (cfg_wr_i)
      begin
         case (sel)
            SGIO_REG_FUNC:
            begin
               func_nxt = merge_bits(func_r, cfg_wdata_i, cfg_be_i); // [RL4]
            end
            SGIO_REG_DIR:
            begin
               dir_nxt = merge_bits(dir_r, cfg_wdata_i, cfg_be_i); // [RL4]
            end
            SGIO_REG_DATA:
            begin
               // Write goes to the drive latch; the readable bits stay the pin level
               latch_nxt = merge_bits(latch_r, cfg_wdata_i, cfg_be_i); // [RL13]
            end
            default:
            begin
               func_nxt = func_r;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         func_r <= `SGIO_FUNC_RST; // [RL7]
         dir_r <= `SGIO_DIR_RST; // [RL7]
         latch_r <= `SGIO_LATCH_RST;
         data_r <= `SGIO_DATA_RST;
      end
      else
      begin
         func_r <= func_nxt;
         dir_r <= dir_nxt;
         latch_r <= latch_nxt;
         data_r <= data_nxt;
      end
   end

   // Read port, one cycle of latency; bits above the pins read zero
   always_comb
   begin
      rdata_nxt = '0;
      rvalid_nxt = cfg_rd_i;
      if (cfg_rd_i)
      begin
         case (sel)
            SGIO_REG_FUNC:
            begin
               rdata_nxt[NUM_PINS-1:0] = func_r; // [RL4]
            end
            SGIO_REG_DIR:
            begin
               rdata_nxt[NUM_PINS-1:0] = dir_r; // [RL4]
            end
            SGIO_REG_DATA:
            begin
               rdata_nxt[NUM_PINS-1:0] = data_r; // [RL11]
            end
            default:
            begin
               rdata_nxt = '0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         rdata_r <= '0;
         rvalid_r <= 1'b0;
      end
      else
      begin
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

   assign cfg_rdata_o = rdata_r;
   assign cfg_rvalid_o = rvalid_r;
   assign pin_function_select_o = func_r;
   assign pin_direction_config_o = dir_r;
   assign pin_data_value_o = data_r;
endmodule // sgio_gpio

// [verification/sgio_gpio_props.sv]
`include "sgio_defs.svh"
module sgio_gpio_props
   import sgio_pkg::*;
#(
   parameter int NUM_PINS = 11,
   parameter int SAMPLE_CYC = 3
)
(
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic cfg_rd_i,
   input wire logic [`SGIO_CFG_WIDTH-1:0] cfg_rdata_o,
   input wire logic cfg_rvalid_o,
   input wire logic [NUM_PINS-1:0] pin_function_select_o,
   input wire logic [NUM_PINS-1:0] pin_direction_config_o,
   input wire logic [NUM_PINS-1:0] pin_data_value_o,
   input wire logic [NUM_PINS-1:0] gpio_in_i,
   input wire logic [NUM_PINS-1:0] gpio_out_o,
   input wire logic [NUM_PINS-1:0] gpio_oe_o,
   input wire logic port2_reset_out_n_i,
   input wire logic expander0_irq_in_n_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_b_i);
   logic [3:0] gap_r;
   logic [3:0] gap_nxt;
   logic [NUM_PINS-1:0] last_r;
   // Cycles since the data register last moved, saturating
   always_comb
   begin
      gap_nxt = (gap_r == 4'hf) ? gap_r : gap_r + 4'h1;
      if (pin_data_value_o != last_r)
         gap_nxt = 4'h1;
   end
   always_ff @(posedge mclk_i)
   begin
      gap_r <= rst_b_i ? gap_nxt : 4'hf;
      last_r <= pin_data_value_o;
   end
   sequence s_gp2;
      !pin_function_select_o[2] [*2];
   endsequence
   sequence s_alt2;
      pin_function_select_o[2] [*4];
   endsequence
   sequence s_still;
      $stable(gpio_in_i) [*6];
   endsequence
   a_reset_to_input: assert property (disable iff (1'b0) !rst_b_i |=>
      gpio_oe_o == '0 && pin_function_select_o == '0 && pin_direction_config_o == '0)
      else $error("pins not inputs after reset");
   a_read_answer: assert property (cfg_rvalid_o == $past(cfg_rd_i))
      else $error("read answer not one cycle later");
   a_rdata_upper: assert property (cfg_rdata_o[`SGIO_CFG_WIDTH-1:NUM_PINS] == '0)
      else $error("read data above pin bits not zero");
   a_oe_mode: assert property (gpio_oe_o == $past((~pin_function_select_o &
      pin_direction_config_o) | (pin_function_select_o & `SGIO_ALT_OUT_MASK)))
      else $error("output enable does not follow mode");
   a_alt_reset_out: assert property ($past(pin_function_select_o[0]) |->
      gpio_out_o[0] == $past(port2_reset_out_n_i))
      else $error("port 2 reset not on pin 0");
   a_irq_idle: assert property (s_gp2 |-> expander0_irq_in_n_o)
      else $error("unused expander interrupt not inactive");
   a_irq_follow: assert property (s_alt2 |->
      expander0_irq_in_n_o == $past(gpio_in_i[2], 3))
      else $error("expander interrupt does not follow pin 2");
   a_sample_gap: assert property (pin_data_value_o != last_r |-> gap_r >= SAMPLE_CYC)
      else $error("data register sampled too often");
   a_data_level: assert property (s_still |-> pin_data_value_o == gpio_in_i)
      else $error("data register not the pin level");
endmodule // sgio_gpio_props

bind sgio_gpio sgio_gpio_props #(.NUM_PINS(NUM_PINS), .SAMPLE_CYC(SAMPLE_CYC)) props_inst (
   .mclk_i, .rst_b_i, .cfg_rd_i, .cfg_rdata_o, .cfg_rvalid_o, .pin_function_select_o,
   .pin_direction_config_o, .pin_data_value_o, .gpio_in_i, .gpio_out_o, .gpio_oe_o,
   .port2_reset_out_n_i, .expander0_irq_in_n_o);

// [verification/tb_top.sv]
`include "sgio_defs.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import sgio_pkg::*;
   logic mclk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic cfg_wr_i = 1'b0;
   logic cfg_rd_i = 1'b0;
   logic [1:0] cfg_sel_i = 2'h0;
   logic [31:0] cfg_wdata_i = '0;
   logic [3:0] cfg_be_i = 4'hf;
   logic [31:0] cfg_rdata_o;
   logic cfg_rvalid_o;
   logic [10:0] pin_function_select_o, pin_direction_config_o, pin_data_value_o;
   logic [10:0] gpio_out_o, gpio_oe_o;
   logic [10:0] ext = '0;
   logic [4:0] src = 5'h1f;
   logic expander0_irq_in_n_o, expander1_irq_in_n_o, expander2_irq_in_n_o;
   // Board loopback: a driven pad reads back its own drive
   wire logic [10:0] gpio_in_i = (gpio_oe_o & gpio_out_o) | (~gpio_oe_o & ext);
   wire logic port2_reset_out_n_i = src[0];
   wire logic port4_reset_out_n_i = src[1];
   wire logic general_event_out_n_i = src[2];
   wire logic port3_reset_out_n_i = src[3];
   wire logic port5_reset_out_n_i = src[4];
   int bad_count = 0;
   int checks = 0;

   sgio_gpio sgio_gpio_inst (.mclk_i, .rst_b_i, .cfg_wr_i, .cfg_rd_i, .cfg_sel_i,
      .cfg_wdata_i, .cfg_be_i, .cfg_rdata_o, .cfg_rvalid_o, .pin_function_select_o,
      .pin_direction_config_o, .pin_data_value_o, .gpio_in_i, .gpio_out_o, .gpio_oe_o,
      .port2_reset_out_n_i, .port3_reset_out_n_i, .port4_reset_out_n_i,
      .port5_reset_out_n_i, .general_event_out_n_i, .expander0_irq_in_n_o,
      .expander1_irq_in_n_o, .expander2_irq_in_n_o);

   initial forever #25 mclk_i = ~mclk_i;

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [1:0] s, input logic [10:0] d, input logic [3:0] b);
      cfg_wr_i = 1'b1;
      cfg_sel_i = s;
      cfg_wdata_i = {21'h0, d};
      cfg_be_i = b;
      @(negedge mclk_i);
      cfg_wr_i = 1'b0;
      @(negedge mclk_i);
   endtask

   task automatic rd(input logic [1:0] s, input logic [10:0] e, input string n);
      cfg_rd_i = 1'b1;
      cfg_sel_i = s;
      @(negedge mclk_i);
      chk("rvalid", 32'h1, 32'(cfg_rvalid_o));
      chk(n, {21'h0, e}, cfg_rdata_o);
      cfg_rd_i = 1'b0;
      @(negedge mclk_i);
   endtask

   function automatic logic [10:0] exp_oe(input logic [10:0] f, input logic [10:0] d);
      return (f & `SGIO_ALT_OUT_MASK) | (~f & d);
   endfunction

   function automatic logic [10:0] exp_out(input logic [10:0] f, input logic [10:0] l,
      input logic [4:0] s);
      return (f & {s[4], s[3], 1'b0, s[2], 5'h0, s[1], s[0]}) | (~f & l);
   endfunction

   initial
   begin
      logic [10:0] f, d, l, eoe, pad;
      void'($urandom(13));
      repeat (2) @(negedge mclk_i);
      rst_b_i = 1'b1;
      chk("oe", 32'h0, 32'(gpio_oe_o));
      rd(2'h0, 11'h000, "func");
      rd(2'h1, 11'h000, "dir");
      rd(2'h3, 11'h000, "unmapped");
      wr(2'h3, 11'h7ff, 4'hf);
      rd(2'h0, 11'h000, "func after unmapped");
      wr(2'h1, 11'h7ff, 4'h1);
      rd(2'h1, 11'h0ff, "dir lanes");
      $display("test reset and lanes done");
      for (int k = 0; k < 40; k++)
      begin
         f = 11'($urandom);
         d = 11'($urandom);
         l = 11'($urandom);
         ext = 11'($urandom);
         src = 5'($urandom);
         if (k == 0)
            f = 11'h7ff;
         if (k == 1)
            {f, d} = {11'h000, 11'h7ff};
         wr(2'h0, f, 4'hf);
         wr(2'h1, d, 4'hf);
         wr(2'h2, l, 4'hf);
         repeat (8) @(negedge mclk_i);
         eoe = exp_oe(f, d);
         pad = (eoe & exp_out(f, l, src)) | (~eoe & ext);
         chk("oe", 32'(eoe), 32'(gpio_oe_o));
         chk("out", 32'(eoe & pad), 32'(gpio_oe_o & gpio_out_o));
         chk("irq", 32'(3'(~f[4:2] | pad[4:2])),
            32'({expander2_irq_in_n_o, expander1_irq_in_n_o, expander0_irq_in_n_o}));
         rd(2'h2, pad, "data");
         rd(2'h0, f, "func");
      end
      $display("test random modes done");
      rst_b_i = 1'b0;
      repeat (2) @(negedge mclk_i);
      rst_b_i = 1'b1;
      chk("oe", 32'h0, 32'(gpio_oe_o));
      rd(2'h0, 11'h000, "func");
      $display("test second reset done");
      final_report();
   end

   initial
   begin
      #200000;
      bad_count++;
      final_report();
   end
endmodule // tb_top
